// File: logic/regulator_a_voltage_regs.sv
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module regulator_a_voltage_regs
  import regv_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  // ****************************************
  // classic wishbone slave
  // ****************************************
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [ADDR_W-1:0]           wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [DATA_W-1:0]           wb_dat_i,
  output logic      [DATA_W-1:0]           wb_dat_o,
  output logic                             wb_ack_o,
  // ****************************************
  // surrounding power manager state
  // ****************************************
  input  wire logic                        voltSetSelB,
  input  wire logic [NUM_RAILS-1:0]        bSleepSelect,
  input  wire logic [1:0]                  core1OperatingMode,
  input  wire logic [1:0]                  processorOperatingMode,
  input  wire logic [1:0]                  memoryOperatingMode,
  input  wire logic [1:0]                  ioOperatingMode,
  input  wire logic [1:0]                  peripheralOperatingMode,
  // ****************************************
  // A set fields
  // ****************************************
  output logic                             core1ASleepSelect,
  output logic      [6:0]                  core1AVoltageCode,
  output logic                             processorASleepSelect,
  output logic      [6:0]                  processorAVoltageCode,
  output logic                             memoryASleepSelect,
  output logic      [6:0]                  memoryAVoltageCode,
  output logic                             ioASleepSelect,
  output logic      [6:0]                  ioAVoltageCode,
  output logic                             peripheralASleepSelect,
  output logic      [6:0]                  peripheralAVoltageCode,
  output logic                             linear1ASleepSelect,
  output logic      [5:0]                  linear1AVoltageCode,
  // ****************************************
  // derived rail state
  // ****************************************
  output logic      [NUM_RAILS-1:0][MV_W-1:0] railATargetMv,
  output logic      [NUM_RAILS-1:0]        railSleepActive,
  output logic      [NUM_BUCKS-1:0]        buckAutoActive
);

  // ****************************************
  // reset release
  // ****************************************
  logic rstMeta_ff;
  logic rstSync_ff;

  // two flops release the async reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // ****************************************
  // bus port
  // ****************************************
  reg_access_if acc ();

  wb_slave_port u_port (
    .mclk      (mclk),
    .rstSync_b (rstSync_ff),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_i  (wb_dat_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .acc       (acc)
  );

  // ****************************************
  // setting registers
  // ****************************************
  logic [7:0] setting_ff [NUM_RAILS];
  logic [7:0] wrMask     [NUM_RAILS];
  logic [6:0] codeMask   [NUM_RAILS];
  logic [6:0] railCode   [NUM_RAILS];
  logic [MV_W-1:0] rawMv [NUM_RAILS];
  logic [MV_W-1:0] nxt_railMv [NUM_RAILS];
  rail_mode_t buckMode   [NUM_BUCKS];
  logic [1:0] opModes    [NUM_BUCKS];

  // readback masks reserved bit of the linear rail
  assign acc.rdData = setting_ff[acc.regSel] & wrMask[acc.regSel];

  // operating mode fields gathered per buck
  assign opModes[0] = core1OperatingMode;
  assign opModes[1] = processorOperatingMode;
  assign opModes[2] = memoryOperatingMode;
  assign opModes[3] = ioOperatingMode;
  assign opModes[4] = peripheralOperatingMode;

  for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
    localparam bit IS_LIN = (i == RAIL_LIN1);
    wire logic selWr = acc.wrStb && (acc.regSel == 3'(i));

    assign wrMask[i]   = IS_LIN ? LIN_WR_MASK : BUCK_WR_MASK;
    assign codeMask[i] = IS_LIN ? LIN_CODE_MSK : BUCK_CODE_MSK;
    // code field: bits 6:0 on bucks, 5:0 on linear
    assign railCode[i] = setting_ff[i][6:0] & codeMask[i];
    // base plus step per code
    assign rawMv[i] = BASE_MV[i] + MV_W'(STEP_MV[i] * {5'h00, railCode[i]});
    // linear rail saturates at its top voltage
    assign nxt_railMv[i] = (IS_LIN && rawMv[i] > LIN_TOP_MV) ? LIN_TOP_MV : rawMv[i];

    // write stores only the writable bits
    always_ff @(posedge mclk or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
        setting_ff[i] <= SETTING_RESET;
      end else if (selWr) begin
        setting_ff[i] <= acc.wrData & wrMask[i];
      end
    end

    // registered target voltage
    always_ff @(posedge mclk or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
        railATargetMv[i] <= '0;
      end else begin
        railATargetMv[i] <= nxt_railMv[i];
      end
    end

    if (IS_LIN) begin : g_lin
      // linear rail: normal or sleep from the active set
      always_ff @(posedge mclk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
          railSleepActive[i] <= 1'b0;
        end else begin
          railSleepActive[i] <= voltSetSelB ? bSleepSelect[i] : setting_ff[i][SLEEP_BIT];
        end
      end
    end else begin : g_buck
      rail_mode_mux u_mode (
        .opMode  (opModes[i]),
        .setSelB (voltSetSelB),
        .aSleep  (setting_ff[i][SLEEP_BIT]),
        .bSleep  (bSleepSelect[i]),
        .mode    (buckMode[i])
      );

      // effective buck state, sleep choice by set when mode is 00
      always_ff @(posedge mclk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
          railSleepActive[i] <= 1'b0;
          buckAutoActive[i]  <= 1'b0;
        end else begin
          railSleepActive[i] <= (buckMode[i] == RAIL_SLEEP);
          buckAutoActive[i]  <= (buckMode[i] == RAIL_AUTO);
        end
      end
    end
  end

  // ****************************************
  // field outputs, straight from the registers
  // ****************************************
  assign core1ASleepSelect      = setting_ff[0][SLEEP_BIT];
  assign core1AVoltageCode      = setting_ff[0][6:0];
  assign processorASleepSelect  = setting_ff[1][SLEEP_BIT];
  assign processorAVoltageCode  = setting_ff[1][6:0];
  assign memoryASleepSelect     = setting_ff[2][SLEEP_BIT];
  assign memoryAVoltageCode     = setting_ff[2][6:0];
  assign ioASleepSelect         = setting_ff[3][SLEEP_BIT];
  assign ioAVoltageCode         = setting_ff[3][6:0];
  assign peripheralASleepSelect = setting_ff[4][SLEEP_BIT];
  assign peripheralAVoltageCode = setting_ff[4][6:0];
  assign linear1ASleepSelect    = setting_ff[5][SLEEP_BIT];
  assign linear1AVoltageCode    = setting_ff[5][5:0];

endmodule : regulator_a_voltage_regs

// File: logic/regv_pkg.sv
package regv_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int          ADDR_W        = 10;
  localparam int          DATA_W        = 32;
  localparam int          NUM_RAILS     = 6;
  localparam int          NUM_BUCKS     = 5;

  // ****************************************
  // register indexes (byte address = index * 4)
  // ****************************************
  localparam logic [7:0]  IDX_CORE1     = 8'hA4;
  localparam logic [7:0]  IDX_PROC      = 8'hA5;
  localparam logic [7:0]  IDX_MEM       = 8'hA6;
  localparam logic [7:0]  IDX_IO        = 8'hA7;
  localparam logic [7:0]  IDX_PERI      = 8'hA8;
  localparam logic [7:0]  IDX_LIN1      = 8'hA9;
  localparam int          RAIL_LIN1     = 5;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int          SLEEP_BIT     = 7;
  localparam int          LIN_RSVD_BIT  = 6;
  localparam logic [7:0]  SETTING_RESET = 8'h00;
  localparam logic [7:0]  BUCK_WR_MASK  = 8'hFF;
  localparam logic [7:0]  LIN_WR_MASK   = 8'hBF;
  localparam logic [6:0]  BUCK_CODE_MSK = 7'h7F;
  localparam logic [6:0]  LIN_CODE_MSK  = 7'h3F;

  // ****************************************
  // voltage mapping in millivolts, per rail
  // ****************************************
  localparam int          MV_W          = 12;
  localparam logic [11:0] BASE_MV [NUM_RAILS] = '{12'h12C, 12'h212, 12'h320, 12'h320, 12'h320, 12'h258};
  localparam logic [11:0] STEP_MV [NUM_RAILS] = '{12'h00A, 12'h00A, 12'h014, 12'h014, 12'h014, 12'h014};
  localparam logic [11:0] LIN_TOP_MV    = 12'h708;

  // ****************************************
  // operating mode field of a buck
  // ****************************************
  localparam logic [1:0]  OPM_BY_SET    = 2'h0;
  localparam logic [1:0]  OPM_SLEEP     = 2'h1;
  localparam logic [1:0]  OPM_SYNC      = 2'h2;
  localparam logic [1:0]  OPM_AUTO      = 2'h3;

  typedef enum logic [1:0] {
    RAIL_SYNC,
    RAIL_SLEEP,
    RAIL_AUTO
  } rail_mode_t;

endpackage : regv_pkg

// File: logic/reg_access_if.sv
`timescale 1ns/1ps
interface reg_access_if;
  logic       wrStb;
  logic [7:0] wrData;
  logic [2:0] regSel;
  logic       hit;
  logic [7:0] rdData;

  modport port (output wrStb, output wrData, output regSel, output hit, input rdData);
  modport bank (input wrStb, input wrData, input regSel, input hit, output rdData);
endinterface : reg_access_if

// File: logic/wb_slave_port.sv
`timescale 1ns/1ps
module wb_slave_port
  import regv_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rstSync_b,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  reg_access_if.port             acc
);

  logic              ack_ff;
  logic [DATA_W-1:0] dat_ff;
  wire  logic [7:0]  regIdx  = wb_adr_i[ADDR_W-1:2];
  wire  logic        request = wb_cyc_i & wb_stb_i;
  wire  logic        newReq  = request & ~ack_ff;

  // decode: aligned word inside the bank
  assign acc.hit    = (wb_adr_i[1:0] == 2'h0) && (regIdx >= IDX_CORE1) && (regIdx <= IDX_LIN1);
  assign acc.regSel = 3'(regIdx - IDX_CORE1);
  assign acc.wrData = wb_dat_i[7:0];
  // write lands on the edge that sees ack
  assign acc.wrStb  = request & ack_ff & wb_we_i & wb_sel_i[0] & acc.hit;

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      ack_ff <= newReq;
      if (newReq) begin
        dat_ff <= acc.hit ? {24'h000000, acc.rdData} : '0; // unmapped reads zero
      end
    end
  end

endmodule : wb_slave_port

// File: logic/rail_mode_mux.sv
`timescale 1ns/1ps
module rail_mode_mux
  import regv_pkg::*;
(
  input  wire logic [1:0] opMode,
  input  wire logic       setSelB,
  input  wire logic       aSleep,
  input  wire logic       bSleep,
  output rail_mode_t      mode
);

  // sleep bit of whichever set is active
  wire logic setSleep = setSelB ? bSleep : aSleep;

  always_comb begin
    unique case (opMode)
      OPM_BY_SET: mode = setSleep ? RAIL_SLEEP : RAIL_SYNC;
      OPM_SLEEP:  mode = RAIL_SLEEP;
      OPM_SYNC:   mode = RAIL_SYNC;
      OPM_AUTO:   mode = RAIL_AUTO;
    endcase
  end

endmodule : rail_mode_mux

// File: verification/regulator_a_voltage_regs_asserts.sv
`timescale 1ns/1ps
module regulator_a_voltage_regs_asserts
  import regv_pkg::*;
(
  input wire logic                           mclk,
  input wire logic                           rst_b,
  input wire logic                           wb_cyc_i,
  input wire logic                           wb_stb_i,
  input wire logic                           wb_we_i,
  input wire logic [ADDR_W-1:0]              wb_adr_i,
  input wire logic [3:0]                     wb_sel_i,
  input wire logic [DATA_W-1:0]              wb_dat_i,
  input wire logic [DATA_W-1:0]              wb_dat_o,
  input wire logic                           wb_ack_o,
  input wire logic                           voltSetSelB,
  input wire logic [NUM_RAILS-1:0]           bSleepSelect,
  input wire logic [1:0]                     core1OperatingMode,
  input wire logic                           core1ASleepSelect,
  input wire logic [6:0]                     core1AVoltageCode,
  input wire logic [6:0]                     processorAVoltageCode,
  input wire logic [6:0]                     ioAVoltageCode,
  input wire logic                           linear1ASleepSelect,
  input wire logic [5:0]                     linear1AVoltageCode,
  input wire logic [NUM_RAILS-1:0][MV_W-1:0] railATargetMv,
  input wire logic [NUM_RAILS-1:0]           railSleepActive,
  input wire logic [NUM_BUCKS-1:0]           buckAutoActive
);
  logic [1:0] upCnt_ff;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // settle counter, covers the reset synchroniser
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) upCnt_ff <= 2'h0;
    else if (upCnt_ff != 2'h3) upCnt_ff <= upCnt_ff + 2'h1;
  end
  // ****************************************
  // bus and field checks
  // ****************************************
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  core1_write_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h290
    |=> {core1ASleepSelect, core1AVoltageCode} == $past(wb_dat_i[7:0])) else $error("core1 write lost");
  rsvd_read_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0
    && !(wb_adr_i == 10'h2A4 && wb_dat_o[6])) else $error("reserved read bits set");
  core1_mv_a: assert property (upCnt_ff == 2'h3 |=> railATargetMv[0] ==
    12'h12C + 12'h00A * 12'($past(core1AVoltageCode))) else $error("core1 target wrong");
  proc_mv_a: assert property (upCnt_ff == 2'h3 |=> railATargetMv[1] ==
    12'h212 + 12'h00A * 12'($past(processorAVoltageCode))) else $error("processor target wrong");
  io_mv_a: assert property (upCnt_ff == 2'h3 |=> railATargetMv[3] ==
    12'h320 + 12'h014 * 12'($past(ioAVoltageCode))) else $error("io target wrong");
  lin_mv_a: assert property (upCnt_ff == 2'h3 |=> railATargetMv[5] == ($past(linear1AVoltageCode) >= 6'h3C
    ? 12'h708 : 12'h258 + 12'h014 * 12'($past(linear1AVoltageCode)))) else $error("linear target wrong");
  core1_sleep_a: assert property (upCnt_ff == 2'h3 |=> railSleepActive[0] ==
    ($past(core1OperatingMode) == 2'h0 ? ($past(voltSetSelB) ? $past(bSleepSelect[0]) : $past(core1ASleepSelect))
    : $past(core1OperatingMode) == 2'h1) && buckAutoActive[0] == ($past(core1OperatingMode) == 2'h3))
    else $error("core1 mode wrong");
  lin_sleep_a: assert property (upCnt_ff == 2'h3 |=> railSleepActive[5] ==
    ($past(voltSetSelB) ? $past(bSleepSelect[5]) : $past(linear1ASleepSelect))) else $error("linear sleep wrong");
endmodule : regulator_a_voltage_regs_asserts
bind regulator_a_voltage_regs regulator_a_voltage_regs_asserts i_regulator_a_voltage_regs_asserts (.mclk, .rst_b,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .voltSetSelB,
  .bSleepSelect, .core1OperatingMode, .core1ASleepSelect, .core1AVoltageCode, .processorAVoltageCode,
  .ioAVoltageCode, .linear1ASleepSelect, .linear1AVoltageCode, .railATargetMv, .railSleepActive, .buckAutoActive);

// File: verification/regulator_a_voltage_regs_tb_top.sv
`timescale 1ns/1ps
module regulator_a_voltage_regs_tb_top;
  import regv_pkg::*;
  logic                           mclk, rst_b, cyc, stb, we, ack, selB;
  logic [9:0]                     adr;
  logic [3:0]                     sel;
  logic [31:0]                    dat, rdat, got;
  logic [5:0]                     bSlp, src;
  logic [1:0]                     opm;
  wire  [5:0]                     sa;
  wire  [5:0][6:0]                vc;
  logic [5:0]                     slp;
  logic [4:0]                     au;
  logic [NUM_RAILS-1:0][MV_W-1:0] mv;
  int                             numErrors, nCompared;
  // ****************************************
  // clock and design
  // ****************************************
  always #25 mclk = ~mclk;
  regulator_a_voltage_regs i_regulator_a_voltage_regs (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .voltSetSelB(selB), .bSleepSelect(bSlp), .core1OperatingMode(opm),
    .processorOperatingMode(opm), .memoryOperatingMode(opm), .ioOperatingMode(opm),
    .peripheralOperatingMode(opm), .core1ASleepSelect(sa[0]), .core1AVoltageCode(vc[0]),
    .processorASleepSelect(sa[1]), .processorAVoltageCode(vc[1]), .memoryASleepSelect(sa[2]),
    .memoryAVoltageCode(vc[2]), .ioASleepSelect(sa[3]), .ioAVoltageCode(vc[3]), .peripheralASleepSelect(sa[4]),
    .peripheralAVoltageCode(vc[4]), .linear1ASleepSelect(sa[5]), .linear1AVoltageCode(vc[5][5:0]),
    .railATargetMv(mv), .railSleepActive(slp), .buckAutoActive(au));
  // linear code is one bit narrower
  assign vc[5][6] = 1'b0;
  // ****************************************
  // tasks
  // ****************************************
  task automatic end_sim();
    if (numErrors == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one classic cycle, held until ack
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge mclk);
    {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    got = rdat;
    {cyc, stb, we} <= 3'h0;
    if (n >= 20) begin
      numErrors++;
      end_sim();
    end
  endtask : xfer
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk("read data", got, e);
  endtask : rd
  // write a rail, then check target, sleep bit and read back
  task automatic step(input int r, input logic [7:0] d, input logic [11:0] m);
    xfer(1'b1, 10'h290 + 10'(4 * r), {24'hFFFFFF, d}, 4'h1);
    repeat (2) @(posedge mclk);
    chk("target mv", mv[r], m);
    chk("sleep select", sa[r], d[7]);
    chk("voltage code", vc[r], r == 5 ? d[5:0] : d[6:0]);
    rd(10'h290 + 10'(4 * r), r == 5 ? d & 8'hBF : d);
  endtask : step
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {mclk, rst_b, cyc, stb, we, adr, sel, dat, selB, bSlp, opm} = '0;
    numErrors = 0;
    nCompared = 0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 6; i++) rd(10'h290 + 10'(4 * i), 32'h0);
    chk("core1 reset mv", mv[0], 12'h12C);
    chk("linear reset mv", mv[5], 12'h258);
    step(0, 8'hFF, 12'h622);
    step(0, 8'h05, 12'h15E);
    step(1, 8'hFF, 12'h708);
    step(1, 8'h00, 12'h212);
    step(2, 8'hBF, 12'h80C);
    step(3, 8'hFF, 12'hD0C);
    step(4, 8'h32, 12'h708);
    step(5, 8'hFF, 12'h708);
    step(5, 8'h3A, 12'h6E0);
    // dropped writes: no byte enable, misaligned, unmapped
    xfer(1'b1, 10'h290, 32'h55, 4'h0);
    rd(10'h290, 32'h05);
    xfer(1'b1, 10'h291, 32'h55, 4'h1);
    rd(10'h290, 32'h05);
    xfer(1'b1, 10'h28C, 32'h55, 4'h1);
    rd(10'h28C, 32'h0);
    // effective sleep for every mode and set
    for (int m = 0; m < 4; m++) for (int s = 0; s < 2; s++) begin
      @(posedge mclk);
      {opm, selB, bSlp} <= {2'(m), s[0], 6'h35};
      repeat (3) @(posedge mclk);
      src = s ? 6'h35 : 6'h0C;
      chk("rail sleep", slp, {src[5], m == 0 ? src[4:0] : {5{m == 1}}});
      chk("auto mode", au, {5{m == 3}});
    end
    end_sim();
  end
endmodule : regulator_a_voltage_regs_tb_top
